// [hw/slu_defs.svh]
// slu_defs.svh: offsets, field positions, reset values and counts for the
// set/reset latch unit.
// assumes: included by bare name; holds definitions only.
`ifndef SLU_DEFS_SVH
`define SLU_DEFS_SVH

// register byte offsets on the apb bus
`define SLU_OFF_CONTROL    8'h00
`define SLU_OFF_ENABLES    8'h04
`define SLU_OFF_SYNC       8'h08
`define SLU_OFF_STATUS     8'h0C

// reset values of the writable registers
`define SLU_RST_CONTROL    8'h00
`define SLU_RST_ENABLES    8'h00
`define SLU_RST_SYNC       8'h00

// latch_control fields
`define SLU_CTL_MOD_EN     7
`define SLU_CTL_SEL_HI     6
`define SLU_CTL_SEL_LO     4
`define SLU_CTL_TRUE_EN    3
`define SLU_CTL_INV_EN     2
`define SLU_CTL_SET        1
`define SLU_CTL_RESET      0

// latch_source_enables fields
`define SLU_ENA_PIN_SET    7
`define SLU_ENA_PULSE_SET  6
`define SLU_ENA_C2_SET     5
`define SLU_ENA_C1_SET     4
`define SLU_ENA_PIN_RST    3
`define SLU_ENA_PULSE_RST  2
`define SLU_ENA_C2_RST     1
`define SLU_ENA_C1_RST     0

// comparator sync select fields
`define SLU_SYN_C1         0
`define SLU_SYN_C2         1

// status fields
`define SLU_STA_LATCH      0
`define SLU_STA_C1         1
`define SLU_STA_C2         2
`define SLU_STA_PIN        3

// base period of the internal pulse source, in clock cycles
`define SLU_PULSE_BASE     16

`endif

// [hw/slu_pkg.sv]
// slu_pkg: types shared by the set/reset latch unit.
// assumes: constants live in slu_defs.svh.
package slu_pkg;

  // apb answer state, one-hot
  typedef enum logic [1:0] {
    SLU_ST_IDLE = 2'b01,
    SLU_ST_ACK  = 2'b10
  } slu_bus_state_t;

  // one register byte
  typedef logic [7:0] slu_byte_t;

  // pulse period select field
  typedef logic [2:0] slu_sel_t;

endpackage : slu_pkg

// [hw/slu_pulse_if.sv]
// slu_pulse_if: carries the period select and pulse between the latch core
// and its periodic pulse source.
// assumes: both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface slu_pulse_if;
  slu_pkg::slu_sel_t period_sel; // chosen period
  logic              pulse;      // one-cycle pulse

  modport gen  (input period_sel, output pulse);
  modport user (output period_sel, input pulse);
endinterface : slu_pulse_if
`default_nettype wire

// [hw/slu_pulse_gen.sv]
// slu_pulse_gen: free-running periodic pulse, period = base << select.
// assumes: synchronous active-low reset, single clock.
`include "slu_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module slu_pulse_gen #(
  parameter int PULSE_BASE = `SLU_PULSE_BASE // cycles at select zero
) (
  input  wire logic  clock, // system clock
  input  wire logic  rst_n, // sync reset, active low
  slu_pulse_if.gen   pif    // select in, pulse out
);
  localparam int CW = $clog2(PULSE_BASE * 128) + 1; // counter width

  generate
    if (PULSE_BASE < 1) begin : g_bad_base
      $error("slu_pulse_gen: PULSE_BASE must be at least one");
    end
  endgenerate

  logic [CW-1:0] cnt_q;   // cycles since last pulse
  logic [CW-1:0] cnt_d;
  logic          pulse_q; // registered pulse
  logic          pulse_d;
  logic [CW-1:0] limit;   // last count of the period

  // next count; a shorter select takes effect at once via the >= compare
  always_comb begin
    limit   = CW'((PULSE_BASE << pif.period_sel) - 1);
    pulse_d = 1'b0;
    cnt_d   = cnt_q + CW'(1);
    if (cnt_q >= limit) begin
      cnt_d   = '0;
      pulse_d = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

  assign pif.pulse = pulse_q;
endmodule : slu_pulse_gen
`default_nettype wire

// [hw/slu_latch_unit.sv]
// slu_latch_unit: reset-dominant set/reset latch with selectable sources,
// software strobes, periodic pulse source and gated true/inverted outputs,
// reached over an apb slave.
// assumes: pins and the timer clock are asynchronous to clock; pin direction
// control lives outside this block.
//
// The APB register port and the placing of the registers were decided locally.
`include "slu_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module slu_latch_unit #(
  parameter int ADDR_W     = 8,              // apb address width
  parameter int PULSE_BASE = `SLU_PULSE_BASE // pulse base period, cycles
) (
  input  wire logic              clock,                // 200 mhz clock
  input  wire logic              rst_n,                // sync reset, low
  input  wire logic              psel,                 // apb select
  input  wire logic              penable,              // apb access phase
  input  wire logic              pwrite,               // apb write
  input  wire logic [ADDR_W-1:0] paddr,                // apb byte address
  input  wire logic [31:0]       pwdata,               // apb write data
  output logic                   pready,               // apb ready
  output logic      [31:0]       prdata,               // apb read data
  output logic                   pslverr,              // apb error
  input  wire logic              cmp_one_out,          // comparator one
  input  wire logic              cmp_two_out,          // comparator two
  input  wire logic              latch_external_input, // external pin
  input  wire logic              sync_timer,           // timer clock in
  output logic                   true_out_pin,         // latch value
  output logic                   true_out_drive,       // true pin enable
  output logic                   inv_out_pin,          // inverted value
  output logic                   inv_out_drive         // inverted enable
);

  generate
    if (ADDR_W < 4) begin : g_bad_addr
      $error("slu_latch_unit: ADDR_W must be at least four");
    end
  endgenerate

  // register index after decode
  localparam logic [1:0] IDX_CONTROL = 2'h0;
  localparam logic [1:0] IDX_ENABLES = 2'h1;
  localparam logic [1:0] IDX_SYNC    = 2'h2;
  localparam logic [1:0] IDX_STATUS  = 2'h3;

  // true when the address hits a mapped word
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    lo = 8'(a);
    addr_hit = (a[ADDR_W-1:4] == '0) && (lo[1:0] == 2'h0);
  endfunction : addr_hit

  // register index of a mapped address
  function automatic logic [1:0] addr_idx(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    lo = 8'(a);
    unique case (lo[3:0])
      4'(`SLU_OFF_CONTROL): addr_idx = IDX_CONTROL;
      4'(`SLU_OFF_ENABLES): addr_idx = IDX_ENABLES;
      4'(`SLU_OFF_SYNC):    addr_idx = IDX_SYNC;
      default:              addr_idx = IDX_STATUS;
    endcase
  endfunction : addr_idx

  // pin synchronisers: two flops per asynchronous input
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] raw_in;  // asynchronous inputs
  logic [NSYNC-1:0] meta_q;  // first stage, read only by second stage
  logic [NSYNC-1:0] sync_q;  // second stage, safe to use
  assign raw_in = {sync_timer, latch_external_input, cmp_two_out,
                   cmp_one_out};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // plain two-flop level synchroniser
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic c1_s;   // synchronised comparator one
  logic c2_s;   // synchronised comparator two
  logic pin_s;  // synchronised external pin
  logic tmr_s;  // synchronised timer clock
  assign c1_s  = sync_q[0];
  assign c2_s  = sync_q[1];
  assign pin_s = sync_q[2];
  assign tmr_s = sync_q[3];

  // software-visible registers
  slu_pkg::slu_byte_t ctl_q;     // latch_control, strobes read as zero
  slu_pkg::slu_byte_t ctl_d;
  slu_pkg::slu_byte_t ena_q;     // latch_source_enables
  slu_pkg::slu_byte_t ena_d;
  logic [1:0]         syn_q;     // comparator timer-sync selects
  logic [1:0]         syn_d;
  logic               set_stb_q; // one-cycle software set
  logic               set_stb_d;
  logic               rst_stb_q; // one-cycle software reset
  logic               rst_stb_d;

  // apb answer path
  slu_pkg::slu_bus_state_t st_q; // answer state
  slu_pkg::slu_bus_state_t st_d;
  logic                    pready_q;
  logic                    pready_d;
  logic [31:0]             prdata_q;
  logic [31:0]             prdata_d;
  logic                    pslverr_q;
  logic                    pslverr_d;
  logic                    bus_fire;  // transfer completes this edge
  logic                    wr_fire;   // write to a mapped register

  // comparator timer sampling
  logic tmr_prev_q;  // timer level one cycle ago
  logic c1_tmr_q;    // comparator one held from last timer edge
  logic c1_tmr_d;
  logic c2_tmr_q;    // comparator two held from last timer edge
  logic c2_tmr_d;
  logic tmr_rise;    // timer rising edge seen

  // latch core
  logic latch_q;     // latch state, deliberately never reset
  logic latch_d;
  logic set_any;     // any enabled set source high
  logic rst_any;     // any enabled reset source high
  logic c1_eff;      // comparator one after optional timer sync
  logic c2_eff;      // comparator two after optional timer sync

  // output pin registers
  logic tpin_q, tpin_d;   // true pin value
  logic tdrv_q, tdrv_d;   // true pin drive
  logic ipin_q, ipin_d;   // inverted pin value
  logic idrv_q, idrv_d;   // inverted pin drive

  // pulse source link
  slu_pulse_if pulse_if ();

  slu_pulse_gen #(
    .PULSE_BASE (PULSE_BASE)
  ) u_pulse (
    .clock (clock),
    .rst_n (rst_n),
    .pif   (pulse_if)
  );

  // period select follows the control field directly
  assign pulse_if.period_sel =
    ctl_q[`SLU_CTL_SEL_HI:`SLU_CTL_SEL_LO];

  // the transfer completes in the ack state, one wait cycle after access
  assign bus_fire = (st_q == slu_pkg::SLU_ST_ACK) && psel && penable;
  assign wr_fire  = bus_fire && pwrite && addr_hit(paddr);

  // apb answer: one wait state, data and error settle with pready
  always_comb begin
    st_d      = st_q;
    pready_d  = 1'b0;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    unique case (st_q)
      slu_pkg::SLU_ST_IDLE: begin
        if (psel && penable) begin
          st_d      = slu_pkg::SLU_ST_ACK;
          pready_d  = 1'b1;
          pslverr_d = !addr_hit(paddr);
          prdata_d  = '0;
          if (!pwrite && addr_hit(paddr)) begin
            unique case (addr_idx(paddr))
              // strobe bits always read back as zero
              IDX_CONTROL: prdata_d[7:0] = ctl_q;
              IDX_ENABLES: prdata_d[7:0] = ena_q;
              IDX_SYNC:    prdata_d[1:0] = syn_q;
              IDX_STATUS: begin
                prdata_d[`SLU_STA_LATCH] = latch_q;
                prdata_d[`SLU_STA_C1]    = c1_eff;
                prdata_d[`SLU_STA_C2]    = c2_eff;
                prdata_d[`SLU_STA_PIN]   = pin_s;
              end
            endcase
          end
        end
      end
      slu_pkg::SLU_ST_ACK: begin
        // the master releases after this edge; hold data one more cycle
        st_d = slu_pkg::SLU_ST_IDLE;
      end
    endcase
  end

  // apb answer registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q      <= slu_pkg::SLU_ST_IDLE;
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // register writes; strobes become a single-cycle pulse
  always_comb begin
    ctl_d     = ctl_q;
    ena_d     = ena_q;
    syn_d     = syn_q;
    set_stb_d = 1'b0;
    rst_stb_d = 1'b0;
    if (wr_fire) begin
      unique case (addr_idx(paddr))
        IDX_CONTROL: begin
          ctl_d = pwdata[7:0];
          // strobes are never stored, so no second write is needed
          ctl_d[`SLU_CTL_SET]   = 1'b0;
          ctl_d[`SLU_CTL_RESET] = 1'b0;
          set_stb_d = pwdata[`SLU_CTL_SET];
          rst_stb_d = pwdata[`SLU_CTL_RESET];
        end
        IDX_ENABLES: ena_d = pwdata[7:0];
        IDX_SYNC:    syn_d = pwdata[1:0];
        // status is read only; writes are ignored
        IDX_STATUS:  ena_d = ena_q;
      endcase
    end
  end

  // register file
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl_q     <= `SLU_RST_CONTROL;
      ena_q     <= `SLU_RST_ENABLES;
      syn_q     <= 2'(`SLU_RST_SYNC);
      set_stb_q <= 1'b0;
      rst_stb_q <= 1'b0;
    end else begin
      ctl_q     <= ctl_d;
      ena_q     <= ena_d;
      syn_q     <= syn_d;
      set_stb_q <= set_stb_d;
      rst_stb_q <= rst_stb_d;
    end
  end

  // timer edge reads the second sync flop only, never the first
  assign tmr_rise = tmr_s && !tmr_prev_q;

  // comparator values captured on each timer rising edge
  always_comb begin
    c1_tmr_d = c1_tmr_q;
    c2_tmr_d = c2_tmr_q;
    if (tmr_rise) begin
      c1_tmr_d = c1_s;
      c2_tmr_d = c2_s;
    end
    // a stopped timer freezes the synced value; a limitation of this mode
    c1_eff = syn_q[`SLU_SYN_C1] ? c1_tmr_q : c1_s;
    c2_eff = syn_q[`SLU_SYN_C2] ? c2_tmr_q : c2_s;
  end

  // timer sampling registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tmr_prev_q <= 1'b0;
      c1_tmr_q   <= 1'b0;
      c2_tmr_q   <= 1'b0;
    end else begin
      tmr_prev_q <= tmr_s;
      c1_tmr_q   <= c1_tmr_d;
      c2_tmr_q   <= c2_tmr_d;
    end
  end

  // source gating and reset-dominant latch update; every source is a high
  // level, sampled each cycle, so no edge is needed to act
  always_comb begin
    set_any = set_stb_q
            | (c1_eff && ena_q[`SLU_ENA_C1_SET])
            | (c2_eff && ena_q[`SLU_ENA_C2_SET])
            | (pin_s && ena_q[`SLU_ENA_PIN_SET])
            | (pulse_if.pulse && ena_q[`SLU_ENA_PULSE_SET]);
    rst_any = rst_stb_q
            | (c1_eff && ena_q[`SLU_ENA_C1_RST])
            | (c2_eff && ena_q[`SLU_ENA_C2_RST])
            | (pin_s && ena_q[`SLU_ENA_PIN_RST])
            | (pulse_if.pulse && ena_q[`SLU_ENA_PULSE_RST]);
    latch_d = latch_q;
    if (rst_any) begin
      latch_d = 1'b0;
    end else if (set_any) begin
      latch_d = 1'b1;
    end
  end

  // latch state: no reset term at all, software must initialise it
  always_ff @(posedge clock) begin
    latch_q <= latch_d;
  end

  // pin outputs: module enable and each route enable, independently
  always_comb begin
    tdrv_d = ctl_q[`SLU_CTL_MOD_EN] && ctl_q[`SLU_CTL_TRUE_EN];
    idrv_d = ctl_q[`SLU_CTL_MOD_EN] && ctl_q[`SLU_CTL_INV_EN];
    // gating the value too keeps an unknown latch off an idle pin
    tpin_d = tdrv_d && latch_q;
    ipin_d = idrv_d && !latch_q;
  end

  // output registers; both routes may be on together
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tpin_q <= 1'b0;
      tdrv_q <= 1'b0;
      ipin_q <= 1'b0;
      idrv_q <= 1'b0;
    end else begin
      tpin_q <= tpin_d;
      tdrv_q <= tdrv_d;
      ipin_q <= ipin_d;
      idrv_q <= idrv_d;
    end
  end

  // outputs straight from flops
  assign pready         = pready_q;
  assign prdata         = prdata_q;
  assign pslverr        = pslverr_q;
  assign true_out_pin   = tpin_q;
  assign true_out_drive = tdrv_q;
  assign inv_out_pin    = ipin_q;
  assign inv_out_drive  = idrv_q;

endmodule : slu_latch_unit
`default_nettype wire

// [tb/slu_latch_unit_asserts.sv]
// slu_latch_unit_asserts.sv: port checker for the latch unit, bound in.
// assumes: one clock, sync active-low reset, latch set before outputs on.
`timescale 1ns/1ps
`default_nettype none
module slu_latch_unit_chk #(
  parameter int ADDR_W     = 8, // address width
  parameter int PULSE_BASE = 16 // pulse base period
) (
  input wire logic              clock,                // clock
  input wire logic              rst_n,                // reset, low
  input wire logic              psel,                 // select
  input wire logic              penable,              // access
  input wire logic              pwrite,               // write
  input wire logic [ADDR_W-1:0] paddr,                // address
  input wire logic [31:0]       pwdata,               // write data
  input wire logic              pready,               // ready
  input wire logic [31:0]       prdata,               // read data
  input wire logic              pslverr,              // error
  input wire logic              cmp_one_out,          // comparator 1
  input wire logic              cmp_two_out,          // comparator 2
  input wire logic              latch_external_input, // pin in
  input wire logic              sync_timer,           // timer clock
  input wire logic              true_out_pin,         // true out
  input wire logic              true_out_drive,       // true enable
  input wire logic              inv_out_pin,          // inverted out
  input wire logic              inv_out_drive         // inverted enable
);
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic wr_ctl; // control write completes at this edge
  logic bad_a;  // address outside the map
  assign wr_ctl = psel && penable && pready && pwrite && paddr == '0;
  assign bad_a  = paddr[1:0] != 2'h0 || paddr > 12;
  // one wait state, then a single ready pulse
  AST_ONE_WAIT:
    assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  AST_READY_PULSE:
    assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_MAP:
    assert property (pready |-> pslverr == bad_a)
    else $error("error flag wrong for address");
  AST_STROBE_READ:
    assert property (pready && !pwrite && paddr == '0 |->
      prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0)
    else $error("strobe bits read back set");
  AST_SOFT_SET:
    assert property (wr_ctl && pwdata[7] && pwdata[3] && pwdata[1]
      && !pwdata[0] |-> ##3 true_out_pin && !inv_out_pin)
    else $error("soft set missed");
  // reset strobe wins even with the set strobe in the same write
  AST_SOFT_RST:
    assert property (wr_ctl && pwdata[7] && pwdata[3] && pwdata[0]
      |-> ##3 !true_out_pin)
    else $error("soft reset missed");
  AST_TRUE_GATE:
    assert property (wr_ctl |-> ##2
      true_out_drive == ($past(pwdata[7], 2) && $past(pwdata[3], 2)))
    else $error("true drive not from control");
  AST_INV_GATE:
    assert property (wr_ctl |-> ##2
      inv_out_drive == ($past(pwdata[7], 2) && $past(pwdata[2], 2)))
    else $error("inverted drive not from control");
  AST_TRUE_OFF:
    assert property (!true_out_drive |-> !true_out_pin)
    else $error("true pin live without drive");
  AST_BOTH_OUT:
    assert property (true_out_drive && inv_out_drive |->
      true_out_pin != inv_out_pin)
    else $error("outputs not complementary");
endmodule : slu_latch_unit_chk
bind slu_latch_unit slu_latch_unit_chk #(
  .ADDR_W(ADDR_W), .PULSE_BASE(PULSE_BASE)
) i_chk (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .cmp_one_out(cmp_one_out),
  .cmp_two_out(cmp_two_out), .latch_external_input(latch_external_input),
  .sync_timer(sync_timer), .true_out_pin(true_out_pin),
  .true_out_drive(true_out_drive), .inv_out_pin(inv_out_pin),
  .inv_out_drive(inv_out_drive)
);
`default_nettype wire

// [tb/slu_far_side.sv]
// slu_far_side: comparators, input pin, timer clock and two output pads.
// assumes: levels come from the bench; pads have a weak pull-down.
`timescale 1ns/1ps
`default_nettype none
module slu_far_side (
  input  wire logic c1_lvl,     // comparator 1 level
  input  wire logic c2_lvl,     // comparator 2 level
  input  wire logic pin_lvl,    // external pin level
  input  wire logic timer_run,  // timer clock runs
  input  wire logic t_dir,      // true pad direction, 1 input
  input  wire logic i_dir,      // inverted pad direction
  input  wire logic t_pin,      // true value from block
  input  wire logic t_drv,      // true drive from block
  input  wire logic i_pin,      // inverted value
  input  wire logic i_drv,      // inverted drive
  output logic      c1_out,     // to comparator input
  output logic      c2_out,     // to comparator input
  output logic      pin_out,    // to pin input
  output var logic  timer_clk,  // timer clock
  output logic      t_pad,      // true pad level
  output logic      i_pad       // inverted pad level
);
  assign c1_out  = c1_lvl;
  assign c2_out  = c2_lvl;
  assign pin_out = pin_lvl;
  // pad driven only with direction cleared, else pull-down wins
  assign t_pad = (!t_dir && t_drv) ? t_pin : 1'b0;
  assign i_pad = (!i_dir && i_drv) ? i_pin : 1'b0;
  // timer stands still when stopped; period unrelated to clock
  initial timer_clk = 1'b0;
  always begin
    #7.3;
    if (timer_run) timer_clk = ~timer_clk;
  end
endmodule : slu_far_side
`default_nettype wire

// [tb/tb_slu_latch_unit.sv]
// tb_slu_latch_unit: register-level tests of the set/reset latch unit.
// assumes: design, checker and far-side model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_slu_latch_unit;
  localparam int PB = 2; // short pulse base keeps the run brief
  localparam logic [7:0] CT = 8'h00, EN = 8'h04, SY = 8'h08, ST = 8'h0C;
  logic        clock = 1'b0;   // 200 mhz
  logic        rst_n = 1'b0;   // reset, low
  logic        psel = 1'b0;    // bus select
  logic        penable = 1'b0; // bus access
  logic        pwrite = 1'b0;  // bus write
  logic [7:0]  paddr = 8'h00;  // bus address
  logic [31:0] pwdata = '0;    // bus write data
  logic        pready, pslverr, tpin, tdrv, ipin, idrv, tpad, ipad;
  logic [31:0] prdata;         // bus read data
  logic        c1 = 0, c2 = 0, pin = 0, trun = 0, tdir = 1, idir = 1;
  logic        c1w, c2w, pinw, tmr; // far side to block
  int          error_cnt = 0, checks_done = 0, cyc = 0;
  always #2.5 clock = ~clock;
  slu_latch_unit #(.PULSE_BASE(PB)) i_dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cmp_one_out(c1w),
    .cmp_two_out(c2w), .latch_external_input(pinw), .sync_timer(tmr),
    .true_out_pin(tpin), .true_out_drive(tdrv), .inv_out_pin(ipin),
    .inv_out_drive(idrv));
  slu_far_side i_far (
    .c1_lvl(c1), .c2_lvl(c2), .pin_lvl(pin), .timer_run(trun),
    .t_dir(tdir), .i_dir(idir), .t_pin(tpin), .t_drv(tdrv),
    .i_pin(ipin), .i_drv(idrv), .c1_out(c1w), .c2_out(c2w),
    .pin_out(pinw), .timer_clk(tmr), .t_pad(tpad), .i_pad(ipad));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // one apb transfer; request held until ready seen at an edge
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic er);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) error_cnt++; // bus hang counts as a mismatch
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b1, d, r, e);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b0, '0, r, e);
    chk(nm, r, x);
    chk("error flag", {31'h0, e}, {31'h0, xe});
  endtask : rdc
  // latch state through the status register
  task automatic lat(input logic x);
    logic [31:0] r;
    logic e;
    xfer(ST, 1'b0, '0, r, e);
    chk("latch", {31'h0, r[0]}, {31'h0, x});
  endtask : lat
  task automatic nap(input int n);
    repeat (n) @(posedge clock);
  endtask : nap
  // hang guard, far above the thousand or so cycles needed
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin : main
    int k;
    int n;
    nap(20);
    rst_n <= 1'b1;
    // reset values, access kinds, unmapped addresses
    rdc("control", CT, 32'h0, 1'b0);
    rdc("enables", EN, 32'h0, 1'b0);
    rdc("unmapped", 8'h10, 32'h0, 1'b1);
    rdc("misaligned", 8'h05, 32'h0, 1'b1);
    wr(EN, 32'hFFFF_FFA5);
    rdc("enables", EN, 32'hA5, 1'b0);
    wr(SY, 32'h3);
    rdc("sync", SY, 32'h3, 1'b0);
    wr(SY, 32'h0);
    wr(EN, 32'h0);
    $display("test registers done");
    // software strobes, outputs, module enable
    tdir <= 1'b0;
    idir <= 1'b0;
    wr(CT, 32'h01); // known state before pads see it
    wr(CT, 32'h8E);
    nap(3);
    chk("true pad", {31'h0, tpad}, 32'h1);
    chk("inv pad", {31'h0, ipad}, 32'h0);
    rdc("control", CT, 32'h8C, 1'b0);
    lat(1'b1);
    wr(CT, 32'h8F);
    lat(1'b0);
    wr(CT, 32'h0E);
    nap(3);
    chk("drives", {30'h0, tdrv, idrv}, 32'h0);
    $display("test strobes done");
    // each source alone through its own enable bit
    for (k = 0; k < 8; k++) begin
      wr(CT, k >= 4 ? 32'h8D : 32'h8E); // start from the other state
      wr(EN, 32'h1 << k);
      c1 <= (k % 4 == 0);
      c2 <= (k % 4 == 1);
      pin <= (k % 4 == 3);
      nap(8);
      lat(k >= 4);
      c1 <= 1'b0;
      c2 <= 1'b0;
      pin <= 1'b0;
      wr(EN, 32'h0);
    end
    c1 <= 1'b1;
    c2 <= 1'b1;
    pin <= 1'b1;
    wr(CT, 32'h8D);
    nap(8);
    lat(1'b0); // disabled sources idle
    wr(EN, 32'hF0);
    nap(8);
    lat(1'b1);
    wr(EN, 32'hF8);
    nap(8);
    lat(1'b0);
    c1 <= 1'b0;
    c2 <= 1'b0;
    pin <= 1'b0;
    wr(EN, 32'h0);
    $display("test sources done");
    // comparator through timer sync: frozen, then follows
    wr(SY, 32'h1);
    wr(CT, 32'h8D);
    wr(EN, 32'h10);
    c1 <= 1'b1;
    nap(10);
    lat(1'b0);
    trun <= 1'b1;
    nap(20);
    lat(1'b1);
    trun <= 1'b0;
    c1 <= 1'b0;
    wr(EN, 32'h0);
    wr(SY, 32'h0);
    $display("test timer sync done");
    // every period select: pulse sets latch within one period
    wr(EN, 32'h40);
    for (k = 0; k < 8; k++) begin
      wr(CT, {24'h0, 1'b1, k[2:0], 4'hD});
      nap(3);
      chk("pulse clear", {31'h0, tpin}, 32'h0);
      n = 0;
      while (tpin !== 1'b1 && n < (PB << k) + 8) begin
        @(posedge clock);
        n++;
      end
      chk("pulse wait", {31'h0, n <= (PB << k) + 4}, 32'h1);
    end
    wr(EN, 32'h0);
    lat(1'b1);
    $display("test pulse done");
    // reset mid-run: registers clear, latch untouched
    rst_n <= 1'b0;
    nap(3);
    rst_n <= 1'b1;
    chk("drives", {30'h0, tdrv, idrv}, 32'h0);
    rdc("control", CT, 32'h0, 1'b0);
    lat(1'b1);
    $display("test reset done");
    complete_run();
  end
endmodule : tb_slu_latch_unit
`default_nettype wire
